/* logic/hspc_regs.vh */
// register offsets, reset values and scaling constants of the hall signal path
`ifndef HSPC_REGS_VH
`define HSPC_REGS_VH

// register word offsets
`define HSPC_ADDR_W 4
`define HSPC_OFS_RANGE 4'h0
`define HSPC_OFS_GAIN 4'h1
`define HSPC_OFS_ZERO 4'h2
`define HSPC_OFS_LOWPASS 4'h3
`define HSPC_OFS_TZERO 4'h4
`define HSPC_OFS_LINCOEF 4'h5
`define HSPC_OFS_QUADCOEF 4'h6
`define HSPC_OFS_DACWORD 4'h7
`define HSPC_OFS_EFFGAIN 4'h8

// field widths
`define HSPC_RANGE_W 2
`define HSPC_CODE_W 15
`define HSPC_LP_W 3
`define HSPC_COEF_W 16

// reset values: mid range, gain +1.0, half scale at zero field, filter off
`define HSPC_RANGE_RST 2'h1
`define HSPC_GAIN_RST 15'h5000
`define HSPC_ZERO_RST 15'h4800
`define HSPC_LP_RST 3'h7
`define HSPC_COEF_RST 16'h0000

// range codes
`define HSPC_RANGE_50MT 2'h3
`define HSPC_RANGE_100MT 2'h1
`define HSPC_RANGE_200MT 2'h0

// code zero point and scale: value = (code - 16384) / 4096
`define HSPC_CODE_MID 16'h4000
`define HSPC_FRAC_SH 12

// low-pass: setting 7 bypasses, otherwise shift = 7 - setting
`define HSPC_LP_BYPASS 3'h7
`define HSPC_LP_FRAC 8

// temperature term scaling
`define HSPC_LIN_SH 12
`define HSPC_SQ_SH 12
`define HSPC_QUAD_SH 12

// output limits
`define HSPC_DAC_W 12
`define HSPC_DAC_MAX 12'hfff
`define HSPC_DAC_MIN 12'h000

`endif

/* logic/hspc_core.v */
// hall signal path: low-pass, temperature-compensated gain, offset and 12-bit limiter
// Operation
// [RQ1] hall sample is low-pass filtered, then multiplied by the compensated gain
// [RQ2] programmed offset is added to the gain-scaled sample before limiting
// [RQ3] offset-corrected result is limited to 12 bits and fed to the dac
// [RQ4] temperature sample minus programmed zero point gives temperature difference
// [RQ5] linear term is difference times linear coefficient
// [RQ6] quadratic term is squared difference times quadratic coefficient
// [RQ7] linear plus quadratic terms plus stored gain form the effective gain
// [RQ8] symmetric range by 2-bit code: 3 is 50, 1 is 100, 0 is 200 mT
// [RQ9] software sets the range before calibrating gain and offset
// [RQ10] gain code 15-bit unsigned, gain = (code - 16384) / 4096
// [RQ11] offset code 15-bit unsigned, offset = (code - 16384) / 4096 of full scale
// [RQ12] offset equals the output produced at zero field
// [RQ13] software must calibrate gain and offset per device in the application
// [RQ14] software should avoid gains between -0.5 and +0.5
// [RQ15] 3-bit low-pass setting, eight bandwidths, 7 bypasses, dc gain one
// [RQ16] limiter saturates below zero to 0 and above full scale to 4095
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`include "hspc_regs.vh"
`default_nettype none

module hspc_core #(
    parameter HALL_W = 16,
    parameter TEMP_W = 12
) (
    input wire clk_i,
    input wire srst_i,
    input wire [`HSPC_ADDR_W-1:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    input wire [HALL_W-1:0] hall_sample_i,
    input wire hall_valid_i,
    input wire [TEMP_W-1:0] temp_sample_i,
    input wire temp_valid_i,
    output wire [`HSPC_RANGE_W-1:0] adc_range_o,
    output reg [`HSPC_DAC_W-1:0] dac_word_o,
    output reg dac_valid_o
);

localparam FW = HALL_W + `HSPC_LP_FRAC;
localparam GW = 18;
localparam DW = TEMP_W + 1;
localparam PW = HALL_W + GW;
localparam SW = PW + 1;
localparam LW = DW + `HSPC_COEF_W;
localparam QW = 2 * DW;
localparam KW = QW - `HSPC_SQ_SH + `HSPC_COEF_W;
localparam EW = GW + 2;

////////////////////////////////////////////////////////////////////////////////
// register file

reg [`HSPC_RANGE_W-1:0] field_range_select_r;
reg [`HSPC_CODE_W-1:0] gain_code_r;
reg [`HSPC_CODE_W-1:0] zero_field_level_code_r;
reg [`HSPC_LP_W-1:0] lowpass_setting_r;
reg [TEMP_W-1:0] temp_zero_point_r;
reg [`HSPC_COEF_W-1:0] linear_temp_coeff_r;
reg [`HSPC_COEF_W-1:0] quadratic_temp_coeff_r;
reg signed [GW-1:0] gain_eff_r;

// the adc range follows the register directly; reprogramming it
// invalidates gain and offset calibration, which software redoes [RQ9]
assign adc_range_o = field_range_select_r; // [RQ8]

always @(posedge clk_i) begin
    if (srst_i) begin
        field_range_select_r <= `HSPC_RANGE_RST;
        gain_code_r <= `HSPC_GAIN_RST;
        zero_field_level_code_r <= `HSPC_ZERO_RST;
        lowpass_setting_r <= `HSPC_LP_RST;
        temp_zero_point_r <= {TEMP_W{1'b0}};
        linear_temp_coeff_r <= `HSPC_COEF_RST;
        quadratic_temp_coeff_r <= `HSPC_COEF_RST;
    end else if (reg_wr_i) begin
        case (reg_addr_i)
            `HSPC_OFS_RANGE: field_range_select_r <= reg_wdata_i[`HSPC_RANGE_W-1:0]; // [RQ8]
            `HSPC_OFS_GAIN: gain_code_r <= reg_wdata_i[`HSPC_CODE_W-1:0]; // [RQ10]
            `HSPC_OFS_ZERO: zero_field_level_code_r <= reg_wdata_i[`HSPC_CODE_W-1:0]; // [RQ11]
            `HSPC_OFS_LOWPASS: lowpass_setting_r <= reg_wdata_i[`HSPC_LP_W-1:0]; // [RQ15]
            `HSPC_OFS_TZERO: temp_zero_point_r <= reg_wdata_i[TEMP_W-1:0];
            `HSPC_OFS_LINCOEF: linear_temp_coeff_r <= reg_wdata_i[`HSPC_COEF_W-1:0];
            `HSPC_OFS_QUADCOEF: quadratic_temp_coeff_r <= reg_wdata_i[`HSPC_COEF_W-1:0];
            default: ;
        endcase
    end
end

// read data valid only in the cycle after the read strobe; unmapped reads zero
always @(posedge clk_i) begin
    if (srst_i) begin
        reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
        case (reg_addr_i)
            `HSPC_OFS_RANGE: reg_rdata_o <= {{(32-`HSPC_RANGE_W){1'b0}}, field_range_select_r};
            `HSPC_OFS_GAIN: reg_rdata_o <= {{(32-`HSPC_CODE_W){1'b0}}, gain_code_r};
            `HSPC_OFS_ZERO: reg_rdata_o <= {{(32-`HSPC_CODE_W){1'b0}}, zero_field_level_code_r};
            `HSPC_OFS_LOWPASS: reg_rdata_o <= {{(32-`HSPC_LP_W){1'b0}}, lowpass_setting_r};
            `HSPC_OFS_TZERO: reg_rdata_o <= {{(32-TEMP_W){1'b0}}, temp_zero_point_r};
            `HSPC_OFS_LINCOEF: reg_rdata_o <= {{(32-`HSPC_COEF_W){1'b0}}, linear_temp_coeff_r};
            `HSPC_OFS_QUADCOEF: reg_rdata_o <= {{(32-`HSPC_COEF_W){1'b0}}, quadratic_temp_coeff_r};
            `HSPC_OFS_DACWORD: reg_rdata_o <= {{(32-`HSPC_DAC_W){1'b0}}, dac_word_o};
            // effective gain, sign-extended to the word
            `HSPC_OFS_EFFGAIN: reg_rdata_o <= {{(32-GW){gain_eff_r[GW-1]}}, gain_eff_r};
            default: reg_rdata_o <= 32'h0000_0000;
        endcase
    end else begin
        reg_rdata_o <= 32'h0000_0000;
    end
end

////////////////////////////////////////////////////////////////////////////////
// temperature compensation

reg signed [DW-1:0] temp_diff_r;
reg signed [LW-1:0] lin_prod_r;
reg signed [QW-1:0] sq_r;
reg signed [KW-1:0] quad_prod_r;

wire signed [DW-1:0] temp_diff_nxt;
wire signed [QW-`HSPC_SQ_SH-1:0] sq_scaled;
wire signed [LW-`HSPC_LIN_SH-1:0] lin_term;
wire signed [KW-`HSPC_QUAD_SH-1:0] quad_term;
wire signed [GW-1:0] gain_base;
wire signed [EW-1:0] gain_sum;
wire signed [GW-1:0] gain_max;
wire signed [GW-1:0] gain_min;
reg signed [GW-1:0] gain_eff_nxt;

assign temp_diff_nxt = $signed({1'b0, temp_sample_i}) - $signed({1'b0, temp_zero_point_r}); // [RQ4]
assign sq_scaled = sq_r[QW-1:`HSPC_SQ_SH];
assign lin_term = lin_prod_r[LW-1:`HSPC_LIN_SH];
assign quad_term = quad_prod_r[KW-1:`HSPC_QUAD_SH];
// gain code to signed value, 4096 counts per unit gain [RQ10]
assign gain_base = $signed({{(GW-`HSPC_CODE_W){1'b0}}, gain_code_r}) - $signed(`HSPC_CODE_MID);
assign gain_max = {1'b0, {(GW-1){1'b1}}};
assign gain_min = {1'b1, {(GW-1){1'b0}}};
// three terms can exceed the gain word; sum wide then saturate [RQ7]
assign gain_sum = {{(EW-GW){gain_base[GW-1]}}, gain_base}
    + {{(EW-(LW-`HSPC_LIN_SH)){lin_term[LW-`HSPC_LIN_SH-1]}}, lin_term}
    + {{(EW-(KW-`HSPC_QUAD_SH)){quad_term[KW-`HSPC_QUAD_SH-1]}}, quad_term};

always @* begin
    if (gain_sum > $signed({{(EW-GW){1'b0}}, gain_max})) begin
        gain_eff_nxt = gain_max;
    end else if (gain_sum < $signed({{(EW-GW){1'b1}}, gain_min})) begin
        gain_eff_nxt = gain_min;
    end else begin
        gain_eff_nxt = gain_sum[GW-1:0];
    end
end

// terms are recomputed every cycle so coefficient writes take effect two cycles later, without a new temperature sample
always @(posedge clk_i) begin
    if (srst_i) begin
        temp_diff_r <= {DW{1'b0}};
        lin_prod_r <= {LW{1'b0}};
        sq_r <= {QW{1'b0}};
        quad_prod_r <= {KW{1'b0}};
        gain_eff_r <= {GW{1'b0}};
    end else begin
        if (temp_valid_i) begin
            temp_diff_r <= temp_diff_nxt; // [RQ4]
        end
        lin_prod_r <= temp_diff_r * $signed(linear_temp_coeff_r); // [RQ5]
        sq_r <= temp_diff_r * temp_diff_r; // [RQ6]
        quad_prod_r <= sq_scaled * $signed(quadratic_temp_coeff_r); // [RQ6]
        gain_eff_r <= gain_eff_nxt; // [RQ7]
    end
end

////////////////////////////////////////////////////////////////////////////////
// low-pass stage: first-order recursive, unity dc gain

reg signed [FW-1:0] lp_state_r;
reg lp_valid_r;
wire signed [FW-1:0] lp_in;
wire signed [FW:0] lp_diff;
wire [`HSPC_LP_W-1:0] lp_shift;
wire signed [FW:0] lp_step;
wire signed [FW:0] lp_acc;
wire signed [HALL_W-1:0] lp_out;

assign lp_in = {hall_sample_i, {`HSPC_LP_FRAC{1'b0}}};
assign lp_diff = {lp_in[FW-1], lp_in} - {lp_state_r[FW-1], lp_state_r};
// higher setting means smaller shift and wider bandwidth [RQ15]
assign lp_shift = `HSPC_LP_BYPASS - lowpass_setting_r;
assign lp_step = lp_diff >>> lp_shift;
assign lp_acc = {lp_state_r[FW-1], lp_state_r} + lp_step;
// the state moves toward the input only, so the sum never leaves FW bits
assign lp_out = lp_state_r[FW-1:`HSPC_LP_FRAC];

always @(posedge clk_i) begin
    if (srst_i) begin
        lp_state_r <= {FW{1'b0}};
        lp_valid_r <= 1'b0;
    end else begin
        lp_valid_r <= hall_valid_i;
        if (hall_valid_i) begin
            if (lowpass_setting_r == `HSPC_LP_BYPASS) begin
                lp_state_r <= lp_in; // [RQ15]
            end else begin
                lp_state_r <= lp_acc[FW-1:0]; // [RQ15]
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// gain, offset and limiter

reg signed [PW-1:0] prod_r;
reg prod_valid_r;
wire signed [PW-`HSPC_FRAC_SH-1:0] prod_scaled;
wire signed [PW-`HSPC_FRAC_SH:0] out_sum;
wire signed [PW-`HSPC_FRAC_SH-1:0] offset_val;
reg [`HSPC_DAC_W-1:0] dac_nxt;

always @(posedge clk_i) begin
    if (srst_i) begin
        prod_r <= {PW{1'b0}};
        prod_valid_r <= 1'b0;
    end else begin
        prod_valid_r <= lp_valid_r;
        if (lp_valid_r) begin
            prod_r <= lp_out * gain_eff_r; // [RQ1]
        end
    end
end

assign prod_scaled = prod_r[PW-1:`HSPC_FRAC_SH];
// offset code in dac counts: 4096 counts per full output scale [RQ11]
assign offset_val = $signed({{(PW-`HSPC_FRAC_SH-`HSPC_CODE_W){1'b0}}, zero_field_level_code_r})
    - $signed(`HSPC_CODE_MID);
// at zero field the product is zero and the output is the offset alone [RQ12]
assign out_sum = {prod_scaled[PW-`HSPC_FRAC_SH-1], prod_scaled}
    + {offset_val[PW-`HSPC_FRAC_SH-1], offset_val}; // [RQ2]

always @* begin
    if (out_sum[PW-`HSPC_FRAC_SH]) begin
        dac_nxt = `HSPC_DAC_MIN; // [RQ16]
    end else if (out_sum > $signed({{(PW-`HSPC_FRAC_SH+1-`HSPC_DAC_W){1'b0}}, `HSPC_DAC_MAX})) begin
        dac_nxt = `HSPC_DAC_MAX; // [RQ16]
    end else begin
        dac_nxt = out_sum[`HSPC_DAC_W-1:0]; // [RQ3]
    end
end

always @(posedge clk_i) begin
    if (srst_i) begin
        dac_word_o <= `HSPC_DAC_MIN;
        dac_valid_o <= 1'b0;
    end else begin
        dac_valid_o <= prod_valid_r;
        if (prod_valid_r) begin
            dac_word_o <= dac_nxt; // [RQ3]
        end
    end
end

endmodule // hspc_core

`default_nettype wire

/* bench/hspc_chk_assertions.sv */
// port assertions for the hall signal path
`default_nettype none
module hspc_chk #(
    parameter HALL_W = 16,
    parameter TEMP_W = 12
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [HALL_W-1:0] hall_sample_i,
    input wire logic hall_valid_i,
    input wire logic [TEMP_W-1:0] temp_sample_i,
    input wire logic temp_valid_i,
    input wire logic [1:0] adc_range_o,
    input wire logic [11:0] dac_word_o,
    input wire logic dac_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    sequence s_take; hall_valid_i; endsequence
    sequence s_out; ##3 dac_valid_o; endsequence
    property p_lat; s_take |-> s_out; endproperty
    a_lat: assert property (p_lat) else $error("result late");
    property p_cause; dac_valid_o |-> $past(hall_valid_i, 3); endproperty
    a_cause: assert property (p_cause) else $error("spurious result");
    property p_hold; !dac_valid_o |-> $stable(dac_word_o); endproperty
    a_hold: assert property (p_hold) else $error("word moved");
    property p_rng; reg_wr_i && reg_addr_i == 4'h0 |=> adc_range_o == $past(reg_wdata_i[1:0]); endproperty
    a_rng: assert property (p_rng) else $error("range not taken");
    property p_rngh; !(reg_wr_i && reg_addr_i == 4'h0) |=> $stable(adc_range_o); endproperty
    a_rngh: assert property (p_rngh) else $error("range moved");
    property p_gain; reg_rd_i && reg_addr_i == 4'h1 |=> reg_rdata_o[31:15] == 17'h0; endproperty
    a_gain: assert property (p_gain) else $error("gain wide");
    property p_rdw; reg_rd_i && reg_addr_i == 4'h7 |=> reg_rdata_o == {20'h0, $past(dac_word_o)}; endproperty
    a_rdw: assert property (p_rdw) else $error("word readback");
    property p_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data stuck");
endmodule // hspc_chk
bind hspc_core hspc_chk #(.HALL_W(HALL_W), .TEMP_W(TEMP_W)) u_chk (.clk_i(clk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .hall_sample_i(hall_sample_i), .hall_valid_i(hall_valid_i),
    .temp_sample_i(temp_sample_i), .temp_valid_i(temp_valid_i), .adc_range_o(adc_range_o),
    .dac_word_o(dac_word_o), .dac_valid_o(dac_valid_o));
`default_nettype wire

/* bench/hspc_frontend_model.sv */
// hall converter stand-in: a burst of equal samples
`default_nettype none
module hspc_frontend_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [15:0] level_i,
    input wire logic [15:0] count_i,
    input wire logic [3:0] gap_i,
    output logic [15:0] hall_sample_o,
    output logic hall_valid_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] left_r = 16'h0;
    logic [3:0] wait_r = 4'h0;
    initial begin
        hall_sample_o = 16'h0;
        hall_valid_o = 1'h0;
    end
    assign busy_o = left_r != 16'h0;
    always @(posedge clk_i) begin
        hall_valid_o <= 1'h0;
        // line not held between conversions; it toggles to the inverse of its last value every cycle
        hall_sample_o <= ~hall_sample_o;
        if (start_i) begin
            left_r <= count_i;
            wait_r <= 4'h0;
        end else if (busy_o && wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end else if (busy_o) begin
            hall_valid_o <= 1'h1;
            hall_sample_o <= level_i;
            left_r <= left_r - 16'h1;
            wait_r <= gap_i;
        end
    end
endmodule // hspc_frontend_model
`default_nettype wire

/* bench/hspc_tb.sv */
// self-checking bench of the hall signal path
`include "hspc_regs.vh"
`default_nettype none
module hall_signal_path_calibration_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
$display("Error at %0t: %h vs %h", $time, (a), (e)); end end
    logic clk_i = 1'h0, srst_i = 1'h1, wr = 1'h0, rd = 1'h0, tv = 1'h0, go = 1'h0, hv, busy, dv;
    logic [3:0] adr = 4'h0, gp = 4'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic [15:0] lvl = 16'h0, cnt = 16'h0, hs;
    logic [11:0] ts = 12'h0, dw;
    logic [1:0] rng;
    int errors = 0, n_compared = 0;
    always #2.5 clk_i = ~clk_i;
    hspc_core dut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(adr), .reg_wdata_i(wd), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdat), .hall_sample_i(hs), .hall_valid_i(hv), .temp_sample_i(ts),
        .temp_valid_i(tv), .adc_range_o(rng), .dac_word_o(dw), .dac_valid_o(dv));
    hspc_frontend_model fe (.clk_i(clk_i), .start_i(go), .level_i(lvl), .count_i(cnt), .gap_i(gp),
        .hall_sample_o(hs), .hall_valid_o(hv), .busy_o(busy));
    ////////////////////////////////////////
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr <= 1'h1;
        adr <= a;
        wd <= d;
        @(posedge clk_i);
        wr <= 1'h0;
        #1;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        rd <= 1'h1;
        adr <= a;
        @(posedge clk_i);
        rd <= 1'h0;
        #1;
        `CHK(rdat, e)
    endtask
    task automatic feed(input logic [15:0] v, input logic [15:0] n, input logic [3:0] g);
        @(posedge clk_i);
        lvl <= v;
        cnt <= n;
        gp <= g;
        go <= 1'h1;
        @(posedge clk_i);
        go <= 1'h0;
        #1;
        repeat (70000) if (busy) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task automatic gcase(input logic [14:0] gc, input logic [14:0] o, input logic [15:0] v, input logic [11:0] e);
        wreg(4'h1, {17'h0, gc});
        wreg(4'h2, {17'h0, o});
        feed(v, 16'h3, 4'h2);
        `CHK(dw, e)
    endtask
    task automatic tcase(input logic [11:0] t, input logic [31:0] e);
        @(posedge clk_i);
        ts <= t;
        tv <= 1'h1;
        @(posedge clk_i);
        ts <= ~t;
        tv <= 1'h0;
        repeat (4) @(posedge clk_i);
        rchk(4'h8, e);
    endtask
    task automatic finish_test();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_i);
        srst_i <= 1'h0;
        rchk(4'h0, {30'h0, `HSPC_RANGE_RST});
        rchk(4'h1, {17'h0, `HSPC_GAIN_RST});
        rchk(4'h2, {17'h0, `HSPC_ZERO_RST});
        rchk(4'h3, {29'h0, `HSPC_LP_RST});
        rchk(4'hf, 32'h0);
        wreg(4'h7, 32'h123);
        rchk(4'h7, 32'h0);
        wreg(4'h1, 32'hffff5000);
        rchk(4'h1, 32'h5000);
        for (int rc = 3; rc >= 0; rc--) begin
            wreg(4'h0, 32'(rc));
            `CHK(rng, 2'(rc))
        end
        // range first, and no gain inside plus or minus one half
        wreg(4'h0, 32'h3);
        gcase(15'h5000, 15'h4800, 16'h0, 12'h800);
        gcase(15'h3000, 15'h4800, 16'h3e8, 12'h418);
        gcase(15'h5800, 15'h4000, 16'h3e8, 12'h5dc);
        gcase(15'h4800, 15'h4400, 16'h3e9, 12'h5f4);
        gcase(15'h6000, 15'h4000, 16'hfa0, 12'hfff);
        gcase(15'h5000, 15'h4000, 16'hff9c, 12'h0);
        wreg(4'h4, 32'h64);
        rchk(4'h4, 32'h64);
        wreg(4'h5, 32'h1000);
        tcase(12'ha4, 32'h1040);
        wreg(4'h6, 32'h1000);
        tcase(12'h24, 32'hfc1);
        feed(16'h3e8, 16'h1, 4'h0);
        `CHK(dw, 12'h3d8)
        wreg(4'h5, 32'h0);
        wreg(4'h6, 32'h0);
        tcase(12'h64, 32'h1000);
        for (int s = 0; s < 8; s++) begin
            wreg(4'h3, 32'(s));
            feed(16'hbb8, 16'h7d0, 4'h0);
            feed(16'h3e8, 16'h1, 4'h0);
            `CHK(dw > 12'h3e8, s != 7)
            feed(16'h3e8, 16'h7d0, 4'h0);
            `CHK(dw, 12'h3e8)
        end
        finish_test();
    end
    initial begin
        #400000;
        errors++;
        finish_test();
    end
endmodule // hall_signal_path_calibration_tb_top
`default_nettype wire
